//--- inc/ert_regs.vh
// Register map, field layout, reset values and encodings of the error rate tester.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
`ifndef ERT_REGS_VH
`define ERT_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ERT_ADR_CTRL        8'h00
`define ERT_ADR_CONFIG      8'h04
`define ERT_ADR_DATA_LIMIT  8'h08
`define ERT_ADR_ERROR_LIMIT 8'h0c
`define ERT_ADR_DATA_COUNT  8'h10
`define ERT_ADR_ERROR_COUNT 8'h14
`define ERT_ADR_STATUS      8'h18
`define ERT_ADR_IRQ_STATUS  8'h1c
`define ERT_ADR_IRQ_MASK    8'h20

// ****************************************
// Field positions
// ****************************************
`define ERT_CTRL_START    0
`define ERT_CTRL_STOP     1
`define ERT_CFG_FALLING   0
`define ERT_CFG_INVERT    1
`define ERT_CFG_TYPE_LO   2
`define ERT_CFG_TYPE_HI   4
`define ERT_CFG_GATE_LO   5
`define ERT_CFG_GATE_HI   6
`define ERT_CFG_RESTART   7
`define ERT_CFG_W         8
`define ERT_ST_DONE       0
`define ERT_ST_CLK_ACTIVE 1
`define ERT_ST_SYNC       2
`define ERT_ST_RUNNING    3
`define ERT_IRQ_DONE      0
`define ERT_IRQ_SYNC_LOSS 1
`define ERT_IRQ_W         2

// ****************************************
// Reset values and encodings
// ****************************************
`define ERT_CFG_RESET         8'h00
`define ERT_DATA_LIMIT_RESET  32'h00002710
`define ERT_ERROR_LIMIT_RESET 32'h00000064
`define ERT_GATE_OFF          2'h0
`define ERT_GATE_HIGH         2'h1
`define ERT_GATE_LOW          2'h2
`define ERT_PRBS9             3'h0
`define ERT_PRBS11            3'h1
`define ERT_PRBS15            3'h2
`define ERT_PRBS16            3'h3
`define ERT_PRBS20            3'h4
`define ERT_PRBS21            3'h5
`define ERT_PRBS23            3'h6
`define ERT_SEED_BITS         5'h18

`endif

//--- logic/ert_sync.v
// Three-stage synchroniser for a group of pins from outside the core clock.
// Assumes pins toggle slower than a few core clocks.
`timescale 1ns/1ns
`default_nettype none
module ert_sync #(
  parameter WIDTH = 3
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Only accept a level once two stages agree
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign level_o[g] = lvl_q;
    end
  endgenerate
endmodule // ert_sync
`default_nettype wire

//--- logic/ert_prbs.v
// Reference pseudo-random generator with seven selectable lengths.
// Assumes step_i pulses once per accepted received bit.
`timescale 1ns/1ns
`default_nettype none
`include "ert_regs.vh"
module ert_prbs #(
  parameter LEN = 23
) (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire [2:0] type_i,
  input  wire       step_i,
  input  wire       seed_i,
  input  wire       bit_i,
  output reg        expect_o
);
  reg [LEN-1:0] sr_q;

  // Maximal-length feedback, newest bit in sr_q[0]
  always @* begin
    case (type_i)
      `ERT_PRBS9:  expect_o = sr_q[8] ^ sr_q[4];
      `ERT_PRBS11: expect_o = sr_q[10] ^ sr_q[8];
      `ERT_PRBS15: expect_o = sr_q[14] ^ sr_q[13];
      `ERT_PRBS16: expect_o = sr_q[15] ^ sr_q[14] ^ sr_q[12] ^ sr_q[3];
      `ERT_PRBS20: expect_o = sr_q[19] ^ sr_q[2];
      `ERT_PRBS21: expect_o = sr_q[20] ^ sr_q[18];
      `ERT_PRBS23: expect_o = sr_q[22] ^ sr_q[17];
      default:     expect_o = sr_q[8] ^ sr_q[4];
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sr_q <= {LEN{1'b0}};
    end else if (step_i) begin
      // Seeding loads received bits, afterwards it free-runs
      sr_q <= {sr_q[LEN-2:0], seed_i ? bit_i : expect_o};
    end
  end
endmodule // ert_prbs
`default_nettype wire

//--- logic/ert_tester.v
// Receive-side bit error rate tester with a classic Wishbone register slave.
// Assumes RX pins come from the device under test, asynchronous to CORE_CLK_I.
//
// Behaviour
// - A receive clock from about 100 Hz to 20 MHz is sampled and its edges found.
// - Software picks rising or falling receive edge and normal or inverted data.
// - The reference generator runs one of seven lengths, chosen before a start.
// - After a start the first 24 accepted bits seed the generator, then comparing begins.
// - While comparing every data bit and every mismatching bit is counted.
// - With internal restart, too many errors right after seeding clear the sync flag and restart the run.
// - The run ends when the data bit count reaches its limit.
// - The run ends when the error bit count reaches its own limit.
// - A start command begins a run and a stop command ends it at once.
// - Reset gives rising edge, normal data, limits 10000 and 100, gate off, internal restart, length 9.
// - A done flag is set on a limit, a stop or a sync loss with external restart, and is clear while running.
// - A clock-activity flag is set by a receive clock edge seen after a start.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ert_regs.vh"
module ert_tester #(
  parameter SYNC_WIN = 64,
  parameter SYNC_MAX = 16
) (
  input  wire        CORE_CLK_I,
  input  wire        RESET_N_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [31:0] WB_DAT_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire        WB_WE_I,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  output reg  [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire        RX_CLK_I,
  input  wire        RX_DATA_I,
  input  wire        RX_GATE_I,
  output wire        IRQ_O
);
  // ****************************************
  // States
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEED = 4'h2;
  localparam [3:0] ST_RUN  = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ****************************************
  // Declarations
  // ****************************************
  reg  [3:0]           state_q;
  reg  [3:0]           state_d;
  reg                  ack_q;
  reg  [`ERT_CFG_W-1:0] cfg_q;
  reg  [31:0]          data_lim_q;
  reg  [31:0]          err_lim_q;
  reg  [31:0]          data_cnt_q;
  reg  [31:0]          data_cnt_d;
  reg  [31:0]          err_cnt_q;
  reg  [31:0]          err_cnt_d;
  reg  [4:0]           seed_cnt_q;
  reg  [4:0]           seed_cnt_d;
  reg  [15:0]          win_cnt_q;
  reg  [15:0]          win_cnt_d;
  reg  [15:0]          win_err_q;
  reg  [15:0]          win_err_d;
  reg                  done_q;
  reg                  done_d;
  reg                  sync_q;
  reg                  sync_d;
  reg                  clk_act_q;
  reg                  rclk_q;
  reg  [`ERT_IRQ_W-1:0] irq_st_q;
  reg  [`ERT_IRQ_W-1:0] irq_mask_q;
  reg                  ev_done;
  reg                  ev_loss;
  reg                  step;
  reg                  seeding;
  wire [2:0]           lvl;
  wire                 bus_req;
  wire                 wr;
  wire                 start;
  wire                 stop;
  wire                 rise;
  wire                 fall;
  wire                 bit_evt;
  wire                 rx_bit;
  wire                 gate_ok;
  wire                 accept;
  wire                 expect_bit;
  wire                 mismatch;
  wire [2:0]           prbs_type;
  wire [1:0]           gate_mode;

  // ****************************************
  // Helpers
  // ****************************************
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr[7:2] == ofs[7:2]);
    end
  endfunction

  // ****************************************
  // Pin sampling and edge finding
  // ****************************************
  ert_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESET_N_I),
    .pin_i   ({RX_GATE_I, RX_DATA_I, RX_CLK_I}),
    .level_o (lvl)
  );

  // 250 MHz sampling leaves over ten samples per 20 MHz period
  always @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= lvl[0];
    end
  end

  assign rise      = lvl[0] & ~rclk_q;
  assign fall      = ~lvl[0] & rclk_q;
  assign bit_evt   = cfg_q[`ERT_CFG_FALLING] ? fall : rise;
  assign rx_bit    = lvl[1] ^ cfg_q[`ERT_CFG_INVERT];
  assign prbs_type = cfg_q[`ERT_CFG_TYPE_HI:`ERT_CFG_TYPE_LO];
  assign gate_mode = cfg_q[`ERT_CFG_GATE_HI:`ERT_CFG_GATE_LO];
  assign gate_ok   = (gate_mode == `ERT_GATE_HIGH) ? lvl[2] :
                     (gate_mode == `ERT_GATE_LOW)  ? ~lvl[2] : 1'b1;
  assign accept    = bit_evt & gate_ok;
  assign mismatch  = rx_bit ^ expect_bit;

  // ****************************************
  // Reference generator
  // ****************************************
  ert_prbs #(
    .LEN (23)
  ) u_prbs (
    .clk_i    (CORE_CLK_I),
    .rst_n_i  (RESET_N_I),
    .type_i   (prbs_type),
    .step_i   (step),
    .seed_i   (seeding),
    .bit_i    (rx_bit),
    .expect_o (expect_bit)
  );

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign bus_req  = WB_CYC_I & WB_STB_I;
  assign WB_ACK_O = ack_q;
  // Writes land on the edge that sees ack high
  assign wr       = bus_req & ack_q & WB_WE_I;
  assign start    = wr & hit(WB_ADR_I, `ERT_ADR_CTRL) & WB_SEL_I[0]
                    & WB_DAT_I[`ERT_CTRL_START];
  assign stop     = wr & hit(WB_ADR_I, `ERT_ADR_CTRL) & WB_SEL_I[0]
                    & WB_DAT_I[`ERT_CTRL_STOP];

  always @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      ack_q    <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q & ~WB_WE_I) begin
        if (hit(WB_ADR_I, `ERT_ADR_CONFIG)) begin
          WB_DAT_O <= {{(32-`ERT_CFG_W){1'b0}}, cfg_q};
        end else if (hit(WB_ADR_I, `ERT_ADR_DATA_LIMIT)) begin
          WB_DAT_O <= data_lim_q;
        end else if (hit(WB_ADR_I, `ERT_ADR_ERROR_LIMIT)) begin
          WB_DAT_O <= err_lim_q;
        end else if (hit(WB_ADR_I, `ERT_ADR_DATA_COUNT)) begin
          WB_DAT_O <= data_cnt_q;
        end else if (hit(WB_ADR_I, `ERT_ADR_ERROR_COUNT)) begin
          WB_DAT_O <= err_cnt_q;
        end else if (hit(WB_ADR_I, `ERT_ADR_STATUS)) begin
          WB_DAT_O <= {28'h0000000, ~state_q[0] & ~state_q[3], sync_q, clk_act_q, done_q};
        end else if (hit(WB_ADR_I, `ERT_ADR_IRQ_STATUS)) begin
          WB_DAT_O <= {{(32-`ERT_IRQ_W){1'b0}}, irq_st_q};
        end else if (hit(WB_ADR_I, `ERT_ADR_IRQ_MASK)) begin
          WB_DAT_O <= {{(32-`ERT_IRQ_W){1'b0}}, irq_mask_q};
        end else begin
          // Control and unmapped offsets read as zero
          WB_DAT_O <= 32'h00000000;
        end
      end
    end
  end

  // Configuration is taken live; change it only between runs
  always @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      cfg_q      <= `ERT_CFG_RESET;
      data_lim_q <= `ERT_DATA_LIMIT_RESET;
      err_lim_q  <= `ERT_ERROR_LIMIT_RESET;
      irq_mask_q <= {`ERT_IRQ_W{1'b0}};
    end else if (wr) begin
      if (hit(WB_ADR_I, `ERT_ADR_CONFIG) & WB_SEL_I[0]) begin
        cfg_q <= WB_DAT_I[`ERT_CFG_W-1:0];
      end
      if (hit(WB_ADR_I, `ERT_ADR_DATA_LIMIT)) begin
        data_lim_q <= merge(data_lim_q, WB_DAT_I, WB_SEL_I);
      end
      if (hit(WB_ADR_I, `ERT_ADR_ERROR_LIMIT)) begin
        err_lim_q <= merge(err_lim_q, WB_DAT_I, WB_SEL_I);
      end
      if (hit(WB_ADR_I, `ERT_ADR_IRQ_MASK) & WB_SEL_I[0]) begin
        irq_mask_q <= WB_DAT_I[`ERT_IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      irq_st_q <= {`ERT_IRQ_W{1'b0}};
    end else begin
      // A new event wins over a write-one clear
      if (wr & hit(WB_ADR_I, `ERT_ADR_IRQ_STATUS) & WB_SEL_I[0]) begin
        irq_st_q <= (irq_st_q & ~WB_DAT_I[`ERT_IRQ_W-1:0]) | {ev_loss, ev_done};
      end else begin
        irq_st_q <= irq_st_q | {ev_loss, ev_done};
      end
    end
  end

  assign IRQ_O = |(irq_st_q & irq_mask_q);

  // ****************************************
  // Measurement sequencer
  // ****************************************
  always @* begin
    state_d    = state_q;
    data_cnt_d = data_cnt_q;
    err_cnt_d  = err_cnt_q;
    seed_cnt_d = seed_cnt_q;
    win_cnt_d  = win_cnt_q;
    win_err_d  = win_err_q;
    done_d     = done_q;
    sync_d     = sync_q;
    ev_done    = 1'b0;
    ev_loss    = 1'b0;
    step       = 1'b0;
    seeding    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_IDLE;
      end
      ST_SEED: begin
        seeding = 1'b1;
        if (accept) begin
          step       = 1'b1;
          seed_cnt_d = seed_cnt_q + 5'h01;
          if (seed_cnt_q == `ERT_SEED_BITS - 5'h01) begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (accept) begin
          step       = 1'b1;
          data_cnt_d = data_cnt_q + 32'h00000001;
          err_cnt_d  = err_cnt_q + {31'h00000000, mismatch};
          if (!sync_q) begin
            win_cnt_d = win_cnt_q + 16'h0001;
            win_err_d = win_err_q + {15'h0000, mismatch};
          end
          if (!sync_q && win_err_d == SYNC_MAX[15:0]) begin
            sync_d  = 1'b0;
            ev_loss = 1'b1;
            if (cfg_q[`ERT_CFG_RESTART]) begin
              // External restart waits for software to start again
              state_d = ST_DONE;
              done_d  = 1'b1;
              ev_done = 1'b1;
            end else begin
              state_d    = ST_SEED;
              data_cnt_d = 32'h00000000;
              err_cnt_d  = 32'h00000000;
              seed_cnt_d = 5'h00;
              win_cnt_d  = 16'h0000;
              win_err_d  = 16'h0000;
            end
          end else begin
            if (!sync_q && win_cnt_d == SYNC_WIN[15:0]) begin
              sync_d = 1'b1;
            end
            if (data_cnt_d == data_lim_q || err_cnt_d == err_lim_q) begin
              state_d = ST_DONE;
              done_d  = 1'b1;
              ev_done = 1'b1;
            end
          end
        end
      end
      ST_DONE: begin
        state_d = ST_DONE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (stop && (state_q == ST_SEED || state_q == ST_RUN)) begin
      state_d = ST_DONE;
      done_d  = 1'b1;
      ev_done = 1'b1;
      step    = 1'b0;
    end
    if (start) begin
      state_d    = ST_SEED;
      done_d     = 1'b0;
      sync_d     = 1'b0;
      data_cnt_d = 32'h00000000;
      err_cnt_d  = 32'h00000000;
      seed_cnt_d = 5'h00;
      win_cnt_d  = 16'h0000;
      win_err_d  = 16'h0000;
      ev_done    = 1'b0;
      ev_loss    = 1'b0;
      step       = 1'b0;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      state_q    <= ST_IDLE;
      data_cnt_q <= 32'h00000000;
      err_cnt_q  <= 32'h00000000;
      seed_cnt_q <= 5'h00;
      win_cnt_q  <= 16'h0000;
      win_err_q  <= 16'h0000;
      done_q     <= 1'b0;
      sync_q     <= 1'b0;
      clk_act_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      data_cnt_q <= data_cnt_d;
      err_cnt_q  <= err_cnt_d;
      seed_cnt_q <= seed_cnt_d;
      win_cnt_q  <= win_cnt_d;
      win_err_q  <= win_err_d;
      done_q     <= done_d;
      sync_q     <= sync_d;
      if (start) begin
        clk_act_q <= 1'b0;
      end else if ((rise | fall) && state_q != ST_IDLE) begin
        clk_act_q <= 1'b1;
      end
    end
  end
endmodule // ert_tester
`default_nettype wire

//--- tb/ert_tester_checker.sv
// Assertions on the register slave and interrupt of the error rate tester.
// Assumes it is bound to ert_tester and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "ert_regs.vh"
module ert_tester_checker #(
  parameter SYNC_WIN = 64,
  parameter SYNC_MAX = 16
) (
  input wire logic        CORE_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic        WB_WE_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        RX_CLK_I,
  input wire logic        RX_DATA_I,
  input wire logic        RX_GATE_I,
  input wire logic        IRQ_O
);
  // ****************************************
  // Shadow of the writable registers
  // ****************************************
  logic [31:0] sh_q [0:8];
  logic        rd_ack;
  logic        wr_ack;
  logic [5:0]  aw;
  assign rd_ack = WB_ACK_O && !WB_WE_I;
  assign wr_ack = WB_ACK_O && WB_WE_I;
  assign aw     = WB_ADR_I[7:2];
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      sh_q[1] <= 32'h0;
      sh_q[2] <= `ERT_DATA_LIMIT_RESET;
      sh_q[3] <= `ERT_ERROR_LIMIT_RESET;
      sh_q[8] <= 32'h0;
    end else if (wr_ack && aw <= 6'h8) begin
      for (int i = 0; i < 4; i++) begin
        if (WB_SEL_I[i]) begin
          sh_q[aw[3:0]][8*i +: 8] <= WB_DAT_I[8*i +: 8];
        end
      end
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  chk_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
    else $error("ack without request");
  chk_dat_hold: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
    else $error("read data moved without ack");
  chk_unmapped_zero: assert property (rd_ack && (aw == 6'h0 || aw > 6'h8) |-> WB_DAT_O == 32'h0)
    else $error("command or unmapped read not zero");
  chk_cfg_readback: assert property (
    rd_ack && aw == 6'h1 |-> WB_DAT_O == {24'h0, sh_q[1][7:0]})
    else $error("config readback wrong");
  chk_limit_readback: assert property (
    rd_ack && (aw == 6'h2 || aw == 6'h3) |-> WB_DAT_O == sh_q[aw[3:0]])
    else $error("limit readback wrong");
  chk_mask_readback: assert property (rd_ack && aw == 6'h8 |-> WB_DAT_O == {30'h0, sh_q[8][1:0]})
    else $error("mask readback wrong");
  chk_irq_masked: assert property (wr_ack && aw == 6'h8 && WB_SEL_I[0] && WB_DAT_I[1:0] == 2'h0
    |=> !IRQ_O)
    else $error("interrupt high with mask clear");
  chk_done_excl: assert property (
    rd_ack && aw == 6'h6 |-> !(WB_DAT_O[0] && WB_DAT_O[3]) && WB_DAT_O[31:4] == 28'h0)
    else $error("status done while running");
  cov_done: cover property (rd_ack && aw == 6'h6 && WB_DAT_O[0]);
  cov_irq: cover property (IRQ_O);
  cov_sync_loss: cover property (rd_ack && aw == 6'h7 && WB_DAT_O[1]);
endmodule // ert_tester_checker
bind ert_tester ert_tester_checker #(.SYNC_WIN(SYNC_WIN), .SYNC_MAX(SYNC_MAX)) chk_u (
  .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RX_CLK_I(RX_CLK_I),
  .RX_DATA_I(RX_DATA_I), .RX_GATE_I(RX_GATE_I), .IRQ_O(IRQ_O));
`default_nettype wire

//--- tb/ert_dut_model.sv
// Behavioural device under test: a pseudo-random stream with its own bit clock.
// Assumes the bench holds run_i high for a frame; the clock stands still outside it.
`timescale 1ns/1ns
`default_nettype none
module ert_dut_model (
  input  wire logic       run_i,
  input  wire logic [2:0] type_i,
  input  wire logic       fall_i,
  input  wire logic       inv_i,
  input  wire logic [7:0] err_k_i,
  input  wire logic       junk_i,
  input  wire logic       gpol_i,
  output logic            rx_clk_o,
  output logic            rx_data_o,
  output logic            gate_o
);
  logic [22:0] sr_q = 23'h7fffff;
  logic        ck_q = 1'b0;
  logic        nb;
  int          n;
  // Idle level sits opposite the sampling edge
  assign rx_clk_o = ck_q ^ fall_i;
  initial begin
    rx_data_o = 1'b0;
    gate_o = 1'b0;
  end
  always begin
    wait (run_i === 1'b1);
    n = 0;
    while (run_i === 1'b1) begin
      n = n + 1;
      if (junk_i && n % 3 == 0) begin
        rx_data_o = ~rx_data_o;
        gate_o = ~gpol_i;
      end else begin
        case (type_i)
          3'h0: nb = sr_q[8] ^ sr_q[4];
          3'h1: nb = sr_q[10] ^ sr_q[8];
          3'h2: nb = sr_q[14] ^ sr_q[13];
          3'h3: nb = sr_q[15] ^ sr_q[14] ^ sr_q[12] ^ sr_q[3];
          3'h4: nb = sr_q[19] ^ sr_q[2];
          3'h5: nb = sr_q[20] ^ sr_q[18];
          default: nb = sr_q[22] ^ sr_q[17];
        endcase
        sr_q = {sr_q[21:0], nb};
        // Errors only after the seeding bits, so counts are exact
        rx_data_o = nb ^ inv_i ^ (err_k_i != 8'h0 && n > 24 && n % err_k_i == 0);
        gate_o = gpol_i;
      end
      // Data moves a quarter bit away from either sampling edge, 125 ns per bit
      #31 ck_q = 1'b1;
      #62 ck_q = 1'b0;
      #32;
    end
    rx_data_o = ~rx_data_o;
  end
endmodule // ert_dut_model
`default_nettype wire

//--- tb/ert_tester_tb.sv
// Self-checking bench for the error rate tester over classic Wishbone.
// Assumes ert_dut_model as the stream source; sync window shortened to 8.
`timescale 1ns/1ns
`default_nettype none
`include "ert_regs.vh"
module ert_tester_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        ack;
  logic        irq;
  logic        rx_clk;
  logic        rx_data;
  logic        gate;
  logic        run = 1'b0;
  logic [7:0]  cfg = 8'h0;
  logic [7:0]  err_k = 8'h0;
  logic [31:0] q;
  logic [31:0] q2;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  always #2 clk = ~clk;

  ert_tester #(.SYNC_WIN(8), .SYNC_MAX(4)) dut_u (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dw), .WB_SEL_I(sel),
    .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .RX_CLK_I(rx_clk), .RX_DATA_I(rx_data), .RX_GATE_I(gate), .IRQ_O(irq));

  ert_dut_model mdl_u (
    .run_i(run), .type_i(cfg[4:2]), .fall_i(cfg[0]), .inv_i(cfg[1]), .err_k_i(err_k),
    .junk_i(cfg[6:5] != 2'h0), .gpol_i(cfg[6:5] == 2'h1), .rx_clk_o(rx_clk),
    .rx_data_o(rx_data), .gate_o(gate));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic arm(input logic [7:0] c, input logic [31:0] dl, input logic [31:0] el,
                     input logic [7:0] k);
    wr(`ERT_ADR_CONFIG, {24'h0, c});
    rd(`ERT_ADR_CONFIG);
    chk("config", q, {24'h0, c});
    wr(`ERT_ADR_DATA_LIMIT, dl);
    wr(`ERT_ADR_ERROR_LIMIT, el);
    cfg <= c;
    err_k <= k;
    // Let the clock idle level settle before the start
    repeat (64) @(posedge clk);
    wr(`ERT_ADR_CTRL, 32'h1);
    rd(`ERT_ADR_STATUS);
    chk("status at start", q, 32'h8);
    run <= 1'b1;
  endtask
  task automatic fin();
    do rd(`ERT_ADR_STATUS); while (q[0] !== 1'b1);
    run <= 1'b0;
  endtask
  task automatic counts(input logic [31:0] dc, input logic [31:0] ec);
    rd(`ERT_ADR_DATA_COUNT);
    chk("data count", q, dc);
    rd(`ERT_ADR_ERROR_COUNT);
    chk("error count", q, ec);
  endtask
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      summarize();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ERT_ADR_CONFIG);
    chk("config reset", q, 32'h0);
    rd(`ERT_ADR_DATA_LIMIT);
    chk("data limit reset", q, 32'd10000);
    rd(`ERT_ADR_ERROR_LIMIT);
    chk("error limit reset", q, 32'd100);
    wr(8'h24, 32'hffffffff);
    rd(8'h24);
    chk("unmapped", q, 32'h0);
    xfer(1'b1, `ERT_ADR_DATA_LIMIT, 32'h000000ff, 4'h1);
    rd(`ERT_ADR_DATA_LIMIT);
    chk("lane write", q, 32'h000027ff);
    wr(`ERT_ADR_IRQ_MASK, 32'h1);
    rd(`ERT_ADR_IRQ_MASK);
    chk("irq mask", q, 32'h1);
    // All lengths, both edges, both senses, an error every tenth bit
    for (int t = 0; t < 7; t++) begin
      arm({3'h0, t[2:0], t[1], t[0]}, 32'd64, 32'd100, 8'd10);
      fin();
      counts(32'd64, 32'd6);
      rd(`ERT_ADR_STATUS);
      chk("status at limit", q, 32'h7);
      chk("irq level", {31'h0, irq}, 32'h1);
    end
    wr(`ERT_ADR_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`ERT_ADR_IRQ_STATUS, 32'h1);
    rd(`ERT_ADR_IRQ_STATUS);
    chk("irq cleared", q, 32'h0);
    arm(8'h00, 32'd1000, 32'd5, 8'd10);
    fin();
    counts(32'd46, 32'd5);
    // Off-level bits are junk and must be skipped
    for (int g = 1; g < 3; g++) begin
      arm({1'b0, g[1:0], 5'h0}, 32'd64, 32'd100, 8'd0);
      fin();
      counts(32'd64, 32'd0);
    end
    arm(8'h00, 32'hfffffffe, 32'hfffffffe, 8'd0);
    repeat (2000) @(posedge clk);
    wr(`ERT_ADR_CTRL, 32'h2);
    rd(`ERT_ADR_STATUS);
    chk("stopped", q & 32'h9, 32'h1);
    rd(`ERT_ADR_DATA_COUNT);
    q2 = q;
    repeat (300) @(posedge clk);
    rd(`ERT_ADR_DATA_COUNT);
    chk("count frozen", q, q2);
    run <= 1'b0;
    wr(`ERT_ADR_IRQ_STATUS, 32'h3);
    arm(8'h80, 32'd1000, 32'd1000, 8'd1);
    fin();
    rd(`ERT_ADR_IRQ_STATUS);
    chk("loss external", q, 32'h3);
    rd(`ERT_ADR_STATUS);
    chk("sync flag", q & 32'h4, 32'h0);
    wr(`ERT_ADR_IRQ_STATUS, 32'h3);
    arm(8'h00, 32'd1000, 32'd1000, 8'd1);
    repeat (1500) @(posedge clk);
    rd(`ERT_ADR_IRQ_STATUS);
    chk("loss internal", q, 32'h2);
    rd(`ERT_ADR_STATUS);
    chk("restarted", q & 32'h9, 32'h8);
    wr(`ERT_ADR_CTRL, 32'h2);
    run <= 1'b0;
    summarize();
  end
endmodule // ert_tester_tb
`default_nettype wire
